/* hdl/pcg_bank.v */
// Power pin bank: fixed outputs, bidirectional pins, edge flags, PWM.
// Assumes a classic Wishbone master, 32-bit data, single clock at 25 MHz,
// and all pin inputs sampled on clk_i.
`timescale 1ns/1ps
`include "pcg_regs.vh"

module pcg_bank
(
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output wire [31:0] dat_o,
  output wire ack_o,
  input wire clk32k_i,
  output wire [3:0] power_control_output_pin_o,
  input wire [6:0] power_control_bidir_pin_i,
  output wire [6:0] power_control_bidir_pin_o,
  output wire [6:0] power_control_bidir_pin_oe_n_o,
  output wire subsys_irq_o,
  output wire irq_o
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  reg ack_r;
  reg [31:0] dat_r;
  reg [31:0] dat_nxt;
  reg [3:0] fixed_output_data_r;
  reg [6:0] bidir_output_data_r;
  reg [6:0] bidir_direction_r;
  reg [7:0] pin_function_pwm_r;
  reg [6:0] rise_event_enable_r;
  reg [6:0] fall_event_enable_r;
  reg [6:0] rise_event_flags_r;
  reg [6:0] fall_event_flags_r;
  reg [6:0] pin_event_forward_enable_r;
  reg [1:0] host_if_event_flags_r;
  reg [6:0] irq_status_r;
  reg [6:0] irq_mask_r;
  reg [6:0] pin_meta_r;
  reg [6:0] pin_sync_r;
  reg [6:0] pin_prev_r;
  reg clk32k_meta_r;
  reg clk32k_sync_r;
  reg clk32k_prev_r;
  reg [3:0] pin_out_r;
  wire [5:0] idx;
  wire req;
  wire acc;
  wire wr;
  wire rd;
  wire [7:0] wbyte;
  wire [6:0] rise_ev;
  wire [6:0] fall_ev;
  wire [6:0] pin_event_pending;
  wire slow_tick;
  wire pwm_wave;
  wire [1:0] output2_source_select;
  wire subsystem_event_flag;
  wire interface_event_flag;

  // ------------------------------------------------------------
  // Behaviour notes
  // ------------------------------------------------------------
  // Bus timing:
  //   Every access is answered one cycle after it is presented.
  //   Ack is a single-cycle pulse, so a master that keeps its
  //   strobe high sees a gap before the next answer.
  //   Writes and read side effects act on the ack edge only,
  //   so a request that is withdrawn early has no effect.
  //   Writes with byte lane zero disabled are acked but dropped.
  //   Unmapped indices read zero and ignore writes.
  // Registers:
  //   Each register sits alone in the low byte of its word.
  //   Reserved bits are not stored; most read zero.
  //   The fixed output register reads ones in its upper nibble.
  // Pin inputs:
  //   Pins pass two flops before anyone looks at them.
  //   Edges are seen three edges after the pin moves.
  //   A pulse shorter than one clock may be missed entirely.
  //   Input data shows the synced level whatever the direction,
  //   so a pin driven by the bank reads back its own level.
  // Flags:
  //   Every sticky flag lets a new event win over a clear
  //   landing in the same cycle, so no event is ever lost.
  //   The interrupt status clears only the bits that the
  //   clearing read actually returned.
  // Slow clock and PWM:
  //   The 32.768 kHz clock is sampled as data, not used as a clock.
  //   Its synced rising edges form the PWM tick.
  //   The PWM output is registered and moves once per tick.
  //   Pin 2 adds a register stage after the source selector.
  // Limitations:
  //   The bank clock must be well above twice the slow clock.

  // ------------------------------------------------------------
  // Wishbone slave
  // ------------------------------------------------------------
  // Request is answered one cycle later; write and read-clear act on ack edge
  assign idx = adr_i[7:2];
  assign req = cyc_i & stb_i;
  assign acc = req & ack_r;
  assign wr = acc & we_i & sel_i[0];
  assign rd = acc & ~we_i;
  assign wbyte = dat_i[7:0];

  // Ack pulse: high for one cycle, then low at least one cycle
  always @(posedge clk_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= req & ~ack_r;
  end

  // Read mux; unmapped indices read as zero
  always @*
  begin
    dat_nxt = 32'h00000000;
    if (idx == `PCG_IDX_FIXED_OUT)
      dat_nxt[7:0] = {`PCG_FIXED_RSVD, fixed_output_data_r};
    else if (idx == `PCG_IDX_BIDIR_OUT)
      dat_nxt[6:0] = bidir_output_data_r;
    else if (idx == `PCG_IDX_BIDIR_DIR)
      dat_nxt[6:0] = bidir_direction_r;
    else if (idx == `PCG_IDX_BIDIR_IN)
      dat_nxt[6:0] = pin_sync_r;
    else if (idx == `PCG_IDX_FUNC)
      dat_nxt[7:0] = pin_function_pwm_r;
    else if (idx == `PCG_IDX_RISE_EN)
      dat_nxt[6:0] = rise_event_enable_r;
    else if (idx == `PCG_IDX_FALL_EN)
      dat_nxt[6:0] = fall_event_enable_r;
    else if (idx == `PCG_IDX_RISE_FLG)
      dat_nxt[6:0] = rise_event_flags_r;
    else if (idx == `PCG_IDX_FALL_FLG)
      dat_nxt[6:0] = fall_event_flags_r;
    else if (idx == `PCG_IDX_FWD_EN)
      dat_nxt[6:0] = pin_event_forward_enable_r;
    else if (idx == `PCG_IDX_PENDING)
      dat_nxt[6:0] = pin_event_pending;
    else if (idx == `PCG_IDX_HOST_FLG)
      dat_nxt[1:0] = host_if_event_flags_r;
    else if (idx == `PCG_IDX_IRQ_STAT)
      dat_nxt[6:0] = irq_status_r;
    else if (idx == `PCG_IDX_IRQ_MASK)
      dat_nxt[6:0] = irq_mask_r;
  end

  // Read data captured as ack rises, held while ack is high
  always @(posedge clk_i)
  begin
    if (rst_i)
      dat_r <= 32'h00000000;
    else if (req & ~ack_r)
      dat_r <= dat_nxt;
  end

  assign dat_o = dat_r;
  assign ack_o = ack_r;

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  // Plain read/write registers; reserved bits are not stored
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fixed_output_data_r <= `PCG_FIXED_OUT_RST;
      bidir_output_data_r <= 7'h00;
      bidir_direction_r <= 7'h00;
      pin_function_pwm_r <= 8'h00;
      rise_event_enable_r <= 7'h00;
      fall_event_enable_r <= 7'h00;
      pin_event_forward_enable_r <= 7'h00;
      irq_mask_r <= 7'h00;
    end
    else if (wr)
    begin
      if (idx == `PCG_IDX_FIXED_OUT)
        fixed_output_data_r <= wbyte[3:0];
      else if (idx == `PCG_IDX_BIDIR_OUT)
        bidir_output_data_r <= wbyte[6:0];
      else if (idx == `PCG_IDX_BIDIR_DIR)
        bidir_direction_r <= wbyte[6:0];
      else if (idx == `PCG_IDX_FUNC)
        pin_function_pwm_r <= wbyte;
      else if (idx == `PCG_IDX_RISE_EN)
        rise_event_enable_r <= wbyte[6:0];
      else if (idx == `PCG_IDX_FALL_EN)
        fall_event_enable_r <= wbyte[6:0];
      else if (idx == `PCG_IDX_FWD_EN)
        pin_event_forward_enable_r <= wbyte[6:0];
      else if (idx == `PCG_IDX_IRQ_MASK)
        irq_mask_r <= wbyte[6:0];
    end
  end

  // ------------------------------------------------------------
  // Pin input synchronisers and edge detect
  // ------------------------------------------------------------
  // Two flops per pin, then a history flop for edges
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_meta_r <= 7'h00;
      pin_sync_r <= 7'h00;
      pin_prev_r <= 7'h00;
      clk32k_meta_r <= 1'b0;
      clk32k_sync_r <= 1'b0;
      clk32k_prev_r <= 1'b0;
    end
    else
    begin
      pin_meta_r <= power_control_bidir_pin_i;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
      clk32k_meta_r <= clk32k_i;
      clk32k_sync_r <= clk32k_meta_r;
      clk32k_prev_r <= clk32k_sync_r;
    end
  end

  // Edge events gated by per-pin enables
  assign rise_ev = pin_sync_r & ~pin_prev_r & rise_event_enable_r;
  assign fall_ev = ~pin_sync_r & pin_prev_r & fall_event_enable_r;
  assign slow_tick = clk32k_sync_r & ~clk32k_prev_r;

  // ------------------------------------------------------------
  // Edge flags and interrupts
  // ------------------------------------------------------------
  // Write one clears a flag; a new edge in the same cycle wins
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rise_event_flags_r <= 7'h00;
      fall_event_flags_r <= 7'h00;
    end
    else
    begin
      if (wr && idx == `PCG_IDX_RISE_FLG)
        rise_event_flags_r <= (rise_event_flags_r & ~wbyte[6:0]) | rise_ev;
      else
        rise_event_flags_r <= rise_event_flags_r | rise_ev;
      if (wr && idx == `PCG_IDX_FALL_FLG)
        fall_event_flags_r <= (fall_event_flags_r & ~wbyte[6:0]) | fall_ev;
      else
        fall_event_flags_r <= fall_event_flags_r | fall_ev;
    end
  end

  // Pin pending when either edge flag is set
  assign pin_event_pending = rise_event_flags_r | fall_event_flags_r;
  assign subsystem_event_flag = |(pin_event_pending & pin_event_forward_enable_r);
  assign interface_event_flag = acc;

  // Host flags: set by events, write one clears, set wins
  always @(posedge clk_i)
  begin
    if (rst_i)
      host_if_event_flags_r <= 2'h0;
    else if (wr && idx == `PCG_IDX_HOST_FLG)
      host_if_event_flags_r <= (host_if_event_flags_r & ~wbyte[1:0]) |
                               {subsystem_event_flag, interface_event_flag};
    else
      host_if_event_flags_r <= host_if_event_flags_r | {subsystem_event_flag, interface_event_flag};
  end

  // Sticky status, read clears only the bits that were returned
  always @(posedge clk_i)
  begin
    if (rst_i)
      irq_status_r <= 7'h00;
    else if (rd && idx == `PCG_IDX_IRQ_STAT)
      irq_status_r <= (irq_status_r & ~dat_r[6:0]) | rise_ev | fall_ev;
    else
      irq_status_r <= irq_status_r | rise_ev | fall_ev;
  end

  assign irq_o = |(irq_status_r & irq_mask_r);
  assign subsys_irq_o = subsystem_event_flag;

  // ------------------------------------------------------------
  // PWM and output pins
  // ------------------------------------------------------------
  pcg_pwm u_pwm
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(slow_tick),
    .period_code_i(pin_function_pwm_r[`PCG_FUNC_PER_MSB:`PCG_FUNC_PER_LSB]),
    .width_code_i(pin_function_pwm_r[`PCG_FUNC_WID_MSB:`PCG_FUNC_WID_LSB]),
    .pwm_o(pwm_wave)
  );

  assign output2_source_select = pin_function_pwm_r[`PCG_FUNC_SEL_MSB:`PCG_FUNC_SEL_LSB];

  // Fixed outputs registered; pin 2 takes the selected source
  always @(posedge clk_i)
  begin
    if (rst_i)
      pin_out_r <= `PCG_FIXED_OUT_RST;
    else
    begin
      pin_out_r <= fixed_output_data_r;
      case (output2_source_select)
        `PCG_SEL_DATA: pin_out_r[`PCG_CLK32K_PIN] <= fixed_output_data_r[`PCG_CLK32K_PIN];
        `PCG_SEL_CLK32K: pin_out_r[`PCG_CLK32K_PIN] <= clk32k_sync_r;
        `PCG_SEL_PWM_POS: pin_out_r[`PCG_CLK32K_PIN] <= pwm_wave;
        default: pin_out_r[`PCG_CLK32K_PIN] <= ~pwm_wave;
      endcase
    end
  end

  assign power_control_output_pin_o = pin_out_r;

  // Bidir drive: enable low while the pin is an output
  assign power_control_bidir_pin_o = bidir_output_data_r;
  assign power_control_bidir_pin_oe_n_o = ~bidir_direction_r;

endmodule // pcg_bank

/* hdl/pcg_regs.vh */
// Register indices, field positions and reset values of the power pin bank.
// Assumes a 32-bit Wishbone bus; byte address is four times the index.
`ifndef PCG_REGS_VH
`define PCG_REGS_VH

// ------------------------------------------------------------
// Register indices
// ------------------------------------------------------------
`define PCG_IDX_FIXED_OUT 6'h00
`define PCG_IDX_BIDIR_OUT 6'h01
`define PCG_IDX_BIDIR_DIR 6'h02
`define PCG_IDX_BIDIR_IN 6'h03
`define PCG_IDX_FUNC 6'h04
`define PCG_IDX_RISE_EN 6'h05
`define PCG_IDX_FALL_EN 6'h06
`define PCG_IDX_RISE_FLG 6'h07
`define PCG_IDX_FALL_FLG 6'h08
`define PCG_IDX_FWD_EN 6'h0B
`define PCG_IDX_PENDING 6'h0D
`define PCG_IDX_HOST_FLG 6'h30
`define PCG_IDX_IRQ_STAT 6'h31
`define PCG_IDX_IRQ_MASK 6'h32

// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define PCG_FUNC_PER_MSB 7
`define PCG_FUNC_PER_LSB 5
`define PCG_FUNC_WID_MSB 4
`define PCG_FUNC_WID_LSB 2
`define PCG_FUNC_SEL_MSB 1
`define PCG_FUNC_SEL_LSB 0
`define PCG_SEL_DATA 2'h0
`define PCG_SEL_CLK32K 2'h1
`define PCG_SEL_PWM_POS 2'h2
`define PCG_SEL_PWM_NEG 2'h3
`define PCG_HOST_SUBSYS_BIT 1
`define PCG_HOST_IFACE_BIT 0
`define PCG_FIXED_OUT_RST 4'hF
`define PCG_FIXED_RSVD 4'hF
`define PCG_CLK32K_PIN 2

// ------------------------------------------------------------
// PWM timing in 32.768 kHz clock periods
// ------------------------------------------------------------
`define PCG_PWM_BASE_WIDTH 12'h010
`define PCG_PWM_PERIOD_ADD 3'h2
`define PCG_PWM_CNT_W 15

`endif

/* hdl/pcg_pwm.v */
// PWM waveform generator counting 32.768 kHz clock periods.
// Assumes tick_i is a one-cycle pulse per slow clock period.
`timescale 1ns/1ps
`include "pcg_regs.vh"

module pcg_pwm
(
  input wire clk_i,
  input wire rst_i,
  input wire tick_i,
  input wire [2:0] period_code_i,
  input wire [2:0] width_code_i,
  output wire pwm_o
);

  reg [`PCG_PWM_CNT_W-1:0] cnt_r;
  reg pwm_r;
  wire [11:0] width_len;
  wire [3:0] mult;
  wire [`PCG_PWM_CNT_W-1:0] period_len;

  // Width is 16 shifted by the code, period is width times (code plus two)
  assign width_len = `PCG_PWM_BASE_WIDTH << width_code_i;
  assign mult = {1'b0, period_code_i} + {1'b0, `PCG_PWM_PERIOD_ADD};
  assign period_len = {3'h0, width_len} * {11'h000, mult};

  // ------------------------------------------------------------
  // Period counter and pulse
  // ------------------------------------------------------------
  // Counter wraps at period end; a shrink of period wraps at once
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r <= {`PCG_PWM_CNT_W{1'b0}};
      pwm_r <= 1'b0;
    end
    else if (tick_i)
    begin
      if (cnt_r >= period_len - 1'b1)
        cnt_r <= {`PCG_PWM_CNT_W{1'b0}};
      else
        cnt_r <= cnt_r + 1'b1;
      pwm_r <= (cnt_r < {3'h0, width_len});
    end
  end

  assign pwm_o = pwm_r;

endmodule // pcg_pwm

/* verif/pcg_bank_checker.sv */
// Timing checker for the power pin bank.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module pcg_bank_checker
(
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire clk32k_i,
  input wire [3:0] power_control_output_pin_o,
  input wire [6:0] power_control_bidir_pin_i,
  input wire [6:0] power_control_bidir_pin_o,
  input wire [6:0] power_control_bidir_pin_oe_n_o,
  input wire subsys_irq_o,
  input wire irq_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ----------------------------------------
  // Bus answers
  // ----------------------------------------
  chk_ack_answer: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("no ack after request");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  chk_unmapped_zero: assert property ((ack_o && !we_i && adr_i[7:2] == 6'h09) |-> dat_o == 32'h0)
    else $error("reserved read not zero");

  // ----------------------------------------
  // Pins and interrupts
  // ----------------------------------------
  chk_dir_write: assert property ((ack_o && we_i && sel_i[0] && adr_i[7:2] == 6'h02)
    |=> power_control_bidir_pin_oe_n_o == ~$past(dat_i[6:0]))
    else $error("direction not applied");
  chk_drive_write: assert property ((ack_o && we_i && sel_i[0] && adr_i[7:2] == 6'h01)
    |=> power_control_bidir_pin_o == $past(dat_i[6:0]))
    else $error("drive level not applied");
  chk_reset_pins: assert property ($fell(rst_i) |->
    power_control_output_pin_o == 4'hF && power_control_bidir_pin_oe_n_o == 7'h7F)
    else $error("pins wrong after reset");
  chk_irq_cause: assert property ($rose(irq_o) |->
    ($past(power_control_bidir_pin_i, 3) != $past(power_control_bidir_pin_i, 4)) ||
    ($past(power_control_bidir_pin_i, 4) != $past(power_control_bidir_pin_i, 5)) ||
    $past(ack_o && we_i && adr_i[7:2] == 6'h32))
    else $error("irq rose without cause");
  chk_subsys_cause: assert property ($rose(subsys_irq_o) |->
    ($past(power_control_bidir_pin_i, 3) != $past(power_control_bidir_pin_i, 4)) ||
    ($past(power_control_bidir_pin_i, 4) != $past(power_control_bidir_pin_i, 5)) ||
    $past(ack_o && we_i && adr_i[7:2] == 6'h0B))
    else $error("subsystem request without cause");
endmodule // pcg_bank_checker

bind pcg_bank pcg_bank_checker i_pcg_bank_checker (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .clk32k_i(clk32k_i), .power_control_output_pin_o(power_control_output_pin_o),
  .power_control_bidir_pin_i(power_control_bidir_pin_i),
  .power_control_bidir_pin_o(power_control_bidir_pin_o),
  .power_control_bidir_pin_oe_n_o(power_control_bidir_pin_oe_n_o),
  .subsys_irq_o(subsys_irq_o), .irq_o(irq_o));

/* verif/pcg_board_model.sv */
// Board-side model: pin wire levels and the slow clock.
// Assumes the bench gives the outside level of undriven pins.
`timescale 1ns/1ps
module pcg_board_model
(
  input wire clk_i,
  input wire [6:0] ext_lvl_i,
  input wire [6:0] drive_i,
  input wire [6:0] oe_n_i,
  output wire [6:0] pin_o,
  output reg slow_clk_o
);
  reg [1:0] div_r = 2'h0;
  // Device drive wins while its enable is low
  assign pin_o = (~oe_n_i & drive_i) | (oe_n_i & ext_lvl_i);
  // Free-running slow clock, shortened to eight bank cycles
  initial slow_clk_o = 1'b0;
  always @(posedge clk_i)
  begin
    div_r <= div_r + 2'h1;
    if (div_r == 2'h3)
      slow_clk_o <= ~slow_clk_o;
  end
endmodule // pcg_board_model

/* verif/pcg_bank_bench.sv */
// Self-checking bench of the power pin bank.
// Assumes the board model closes the pin loop.
`timescale 1ns/1ps
module pcg_bank_bench;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg cyc_i = 1'b0;
  reg stb_i = 1'b0;
  reg we_i = 1'b0;
  reg [7:0] adr_i = 8'h00;
  reg [3:0] sel_i = 4'h0;
  reg [31:0] dat_i = 32'h0;
  reg [6:0] ext_lvl = 7'h00;
  wire [31:0] dat_o;
  wire ack_o, slow_clk, subsys_irq_o, irq_o;
  wire [3:0] pwr_o;
  wire [6:0] pin_in, pin_drv, oe_n;
  integer mismatches = 0;
  integer cmp_count = 0;
  integer i;
  reg [31:0] rd;

  always #20 clk_i = ~clk_i;

  pcg_bank i_pcg_bank (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .clk32k_i(slow_clk),
    .power_control_output_pin_o(pwr_o), .power_control_bidir_pin_i(pin_in),
    .power_control_bidir_pin_o(pin_drv), .power_control_bidir_pin_oe_n_o(oe_n),
    .subsys_irq_o(subsys_irq_o), .irq_o(irq_o));
  pcg_board_model i_pcg_board_model (.clk_i(clk_i), .ext_lvl_i(ext_lvl), .drive_i(pin_drv),
    .oe_n_i(oe_n), .pin_o(pin_in), .slow_clk_o(slow_clk));

  // ----------------------------------------
  // Bus cycle and compare
  // ----------------------------------------
  task wb(input reg w, input reg [5:0] idx, input reg [6:0] d, input reg [3:0] s);
    integer n;
    begin
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {idx, 2'h0};
      sel_i <= s;
      dat_i <= {25'h0, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1 && n < 20)
      begin
        @(posedge clk_i);
        n = n + 1;
      end
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask

  task chk(input reg [31:0] got, input reg [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    begin
      chk({oe_n, pwr_o}, {7'h7F, 4'hF});
      for (i = 0; i < 12; i = i + 1)
      begin
        wb(1'b0, i[5:0], 7'h0, 4'h1);
        chk(rd, (i == 0) ? 32'hFF : 32'h0);
      end
    end
  endtask

  task t_pins;
    begin
      wb(1'b1, 6'h00, 7'h05, 4'h1);
      wb(1'b1, 6'h00, 7'h7A, 4'h0);
      repeat (3) @(posedge clk_i);
      chk(pwr_o, 4'h5);
      wb(1'b1, 6'h02, 7'h7F, 4'h1);
      wb(1'b1, 6'h01, 7'h55, 4'h1);
      chk({oe_n, pin_drv}, {7'h00, 7'h55});
      repeat (3) @(posedge clk_i);
      wb(1'b0, 6'h03, 7'h0, 4'h1);
      chk(rd, 32'h55);
      wb(1'b1, 6'h02, 7'h00, 4'h1);
      ext_lvl <= 7'h2A;
      repeat (4) @(posedge clk_i);
      wb(1'b0, 6'h03, 7'h0, 4'h1);
      chk({oe_n, rd[6:0]}, {7'h7F, 7'h2A});
    end
  endtask

  task t_events;
    begin
      wb(1'b1, 6'h05, 7'h01, 4'h1);
      wb(1'b1, 6'h06, 7'h02, 4'h1);
      wb(1'b1, 6'h0B, 7'h03, 4'h1);
      wb(1'b1, 6'h32, 7'h03, 4'h1);
      ext_lvl <= 7'h2D;
      repeat (5) @(posedge clk_i);
      chk({subsys_irq_o, irq_o}, 2'b11);
      wb(1'b0, 6'h07, 7'h0, 4'h1);
      chk(rd, 32'h01);
      wb(1'b0, 6'h08, 7'h0, 4'h1);
      chk(rd, 32'h02);
      wb(1'b0, 6'h0D, 7'h0, 4'h1);
      chk(rd, 32'h03);
      wb(1'b0, 6'h31, 7'h0, 4'h1);
      chk({rd, irq_o}, {32'h03, 1'b0});
      wb(1'b1, 6'h07, 7'h01, 4'h1);
      wb(1'b1, 6'h08, 7'h00, 4'h1);
      wb(1'b0, 6'h07, 7'h0, 4'h1);
      chk(rd, 32'h00);
      wb(1'b0, 6'h08, 7'h0, 4'h1);
      chk(rd, 32'h02);
      wb(1'b0, 6'h30, 7'h0, 4'h1);
      chk(rd[1], 1'b1);
      wb(1'b1, 6'h0B, 7'h01, 4'h1);
      chk(subsys_irq_o, 1'b0);
      wb(1'b1, 6'h30, 7'h02, 4'h1);
      wb(1'b0, 6'h30, 7'h0, 4'h1);
      chk(rd[1], 1'b0);
    end
  endtask

  task t_wave(input reg [6:0] f, input integer win, input integer exp);
    integer hi;
    begin
      hi = 0;
      wb(1'b1, 6'h04, f, 4'h1);
      repeat (600) @(posedge clk_i);
      repeat (win)
      begin
        @(posedge clk_i);
        if (pwr_o[2] === 1'b1)
          hi = hi + 1;
      end
      chk(hi, exp);
    end
  endtask

  task complete_run;
    begin
      if (mismatches == 0 && cmp_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk_i);
    mismatches = mismatches + 1;
    complete_run;
  end

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_pins;
    t_events;
    t_wave(7'h01, 512, 256);
    t_wave(7'h02, 512, 256);
    t_wave(7'h23, 768, 512);
    t_wave(7'h06, 1024, 512);
    complete_run;
  end
endmodule // pcg_bank_bench
